// ==== oss_pkg.sv ====
// Purpose: shared constants and types of the oscillator control block
// Assumes: 8-bit register port, byte offsets
// Notes: no timing figures beyond the start-up cycle count
package oss_pkg;

  localparam int unsigned OSS_AW = 8;
  localparam int unsigned OSS_DW = 8;

  localparam logic [7:0] OSS_CR_ADDR   = 8'h00;
  localparam logic [7:0] OSS_CFG_ADDR  = 8'h04;
  localparam logic [7:0] OSS_STAT_ADDR = 8'h08;

  localparam int unsigned OSS_CR_EREN_BIT = 7;
  localparam int unsigned OSS_CR_STEN_BIT = 5;
  localparam int unsigned OSS_CAP_W       = 4;
  localparam int unsigned OSS_CFG_SEL_BIT = 0;

  localparam int unsigned OSS_ST_STATE_LSB = 0;
  localparam int unsigned OSS_ST_DONE_BIT  = 2;
  localparam int unsigned OSS_ST_EN_BIT    = 3;
  localparam int unsigned OSS_ST_KEEP_BIT  = 4;

  localparam logic             OSS_EREN_RST = 1'b0;
  localparam logic             OSS_STEN_RST = 1'b0;
  localparam logic             OSS_SEL_RST  = 1'b0;
  localparam logic [3:0]       OSS_CAP_RST  = 4'h0;
  localparam logic [7:0]       OSS_RD_ZERO  = 8'h00;

  localparam int unsigned OSS_STARTUP_CYCLES = 4096;
  localparam int unsigned OSS_CNT_W          = 13;
  localparam logic [12:0] OSS_CNT_ZERO       = 13'h0000;
  localparam logic [12:0] OSS_CNT_ONE        = 13'h0001;

  typedef enum logic [1:0] {
    OSS_OFF,
    OSS_STARTUP,
    OSS_STABLE,
    OSS_EXTCLK
  } oss_state_t;

endpackage

// ==== oss_link_if.sv ====
// Purpose: carrier between control logic and raw-clock logic
// Assumes: levels only cross here, each synchronised at its receiver
// Notes: clocks out of the raw domain are gated copies of raw_osc_clk
`timescale 1ns/100ps
interface oss_link_if;
  logic osc_en;
  logic int_sel;
  logic ref_active;
  logic count_done;
  logic out_clk;
  logic ref_clk_out;

  modport ctrl
  (
    output osc_en,
    output int_sel,
    output ref_active,
    input  count_done,
    input  out_clk,
    input  ref_clk_out
  );

  modport raw
  (
    input  osc_en,
    input  int_sel,
    input  ref_active,
    output count_done,
    output out_clk,
    output ref_clk_out
  );
endinterface

// ==== oss_raw_cnt.sv ====
// Purpose: start-up counter and glitch-free output gates on raw_osc_clk
// Assumes: raw_osc_clk may stand still while the oscillator is off
// Notes: counter is cleared asynchronously whenever enable is low
`timescale 1ns/100ps
module oss_raw_cnt
  import oss_pkg::*;
#(
  parameter int unsigned CYCLES = OSS_STARTUP_CYCLES
)
(
  input  wire logic raw_osc_clk,
  input  wire logic rst,
  oss_link_if.raw   lnk
);

  localparam logic [OSS_CNT_W-1:0] LAST = OSS_CNT_W'(CYCLES - 1);

  typedef struct packed {
    logic                 en1;
    logic                 en2;
    logic                 sel1;
    logic                 sel2;
    logic                 ref1;
    logic                 ref2;
    logic [OSS_CNT_W-1:0] cnt;
    logic                 done;
  } oss_raw_t;

  oss_raw_t s_q;
  oss_raw_t s_d;
  logic     gate_q;
  logic     ref_gate_q;
  logic     clr;

  // Raw clock may be dead, so clear cannot wait for an edge
  assign clr = rst | ~lnk.osc_en;

  always_comb
  begin
    s_d      = s_q;
    s_d.en1  = 1'b1;
    s_d.en2  = s_q.en1;
    s_d.sel1 = lnk.int_sel;
    s_d.sel2 = s_q.sel1;
    // Reference enable is a level from the other domain
    s_d.ref1 = lnk.ref_active;
    s_d.ref2 = s_q.ref1;
    if (s_q.en2 && s_q.sel2 && !s_q.done)
    begin
      s_d.cnt = s_q.cnt + OSS_CNT_ONE;
      if (s_q.cnt == LAST)
      begin
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge raw_osc_clk or posedge clr)
  begin
    if (clr)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Gates change on the falling edge, so no pulse is cut short
  always_ff @(negedge raw_osc_clk or posedge clr)
  begin
    if (clr)
    begin
      gate_q     <= 1'b0;
      ref_gate_q <= 1'b0;
    end
    else
    begin
      gate_q     <= s_q.en2 & (~s_q.sel2 | s_q.done);
      ref_gate_q <= s_q.en2 & (~s_q.sel2 | s_q.done) & s_q.ref2;
    end
  end

  assign lnk.count_done  = s_q.done;
  assign lnk.out_clk     = raw_osc_clk & gate_q;
  assign lnk.ref_clk_out = raw_osc_clk & ref_gate_q;

  chk_done_after_count: assert property (
    @(posedge raw_osc_clk) disable iff (clr)
    $rose(s_q.done) |-> $past(s_q.cnt) == LAST)
    else $error("count done without full count");

  chk_gate_before_done: assert property (
    @(posedge raw_osc_clk) disable iff (clr)
    (s_q.sel2 && !s_q.done) |-> !gate_q)
    else $error("output clock open before count done");

endmodule

// ==== oss_top.sv ====
// Purpose: state control of a crystal oscillator block
// Assumes: power-mode and consumer inputs are on ref_clk
// Notes: raw_osc_clk comes from the amplifier or the input pad buffer
//
// Behaviour
// - Off when no consumer needs the clock
// - Off: amplifier off, drive pad released, clock static; input buffer stays on while internal select is clear
// - Enable with internal select enters Start-Up
// - Count 4096 raw cycles before passing clock
// - Stable once enabled, selected and count done
// - Internal select clear: buffer pad clock out
// - External mode leaves drive pad free
// - Counter held cleared while not enabled
// - No reset requests raised
// - Stop keeps running only with both enables
// - Low-leakage stop keeps all register settings
// - Very-low-leakage wake resets all register bits
// - No interrupt outputs
// - Reference enable gates delivered reference clock
// - Stop enable keeps reference clock in stop
`timescale 1ns/100ps
module oss_top
  import oss_pkg::*;
#(
  parameter int unsigned CYCLES = OSS_STARTUP_CYCLES
)
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 raw_osc_clk,
  input  wire logic [OSS_AW-1:0]    addr,
  input  wire logic [OSS_DW-1:0]    wr_data,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  output logic      [OSS_DW-1:0]    rd_data,
  input  wire logic                 consumer_req,
  input  wire logic                 stop_mode,
  input  wire logic                 low_leak_stop,
  input  wire logic                 very_low_leak_stop,
  output logic      [OSS_CAP_W-1:0] load_cap,
  output logic                      amp_enable,
  output logic                      input_buf_enable,
  output logic                      drive_pad_release,
  output logic                      osc_out_clk,
  output logic                      ext_ref_clk
);

  typedef struct packed {
    oss_state_t           st;
    logic                 ext_ref_enable;
    logic                 ext_ref_stop_enable;
    logic [OSS_CAP_W-1:0] cap;
    logic                 internal_osc_select;
    logic                 stop_q;
    logic                 keep;
    logic                 vlls_q;
    logic                 done_s1;
    logic                 done_s2;
    logic [OSS_DW-1:0]    rdata;
  } oss_main_t;

  oss_main_t  s_q;
  oss_main_t  s_d;
  oss_link_if lnk ();

  logic       in_stop;
  logic       stop_entry;
  logic       keep_now;
  logic       osc_need;
  logic       osc_en;
  logic       ref_active;
  logic       vlls_wake;
  logic       running;
  logic [1:0] st_code;

  assign in_stop    = stop_mode | low_leak_stop | very_low_leak_stop;
  assign stop_entry = in_stop & ~s_q.stop_q;
  assign vlls_wake  = s_q.vlls_q & ~very_low_leak_stop;
  assign running    = (s_q.st != OSS_OFF);

  // Both enables are sampled at the moment of entry
  assign keep_now = stop_entry ? (s_q.ext_ref_enable & s_q.ext_ref_stop_enable)
                               : s_q.keep;

  // Reference clock users count as consumers too
  assign osc_need = consumer_req | s_q.ext_ref_enable;

  always_comb
  begin
    if (in_stop)
    begin
      osc_en = keep_now;
    end
    else
    begin
      osc_en = osc_need;
    end
  end

  assign ref_active = s_q.ext_ref_enable & (~in_stop | keep_now);

  always_comb
  begin
    case (s_q.st)
      OSS_OFF:     st_code = 2'h0;
      OSS_STARTUP: st_code = 2'h1;
      OSS_STABLE:  st_code = 2'h2;
      default:     st_code = 2'h3;
    endcase
  end

  always_comb
  begin
    s_d         = s_q;
    s_d.stop_q  = in_stop;
    s_d.vlls_q  = very_low_leak_stop;
    s_d.keep    = in_stop ? keep_now : 1'b0;
    s_d.done_s1 = lnk.count_done;
    s_d.done_s2 = s_q.done_s1;
    s_d.rdata   = OSS_RD_ZERO;

    if (!osc_en)
    begin
      s_d.st = OSS_OFF;
    end
    else
    begin
      case (s_q.st)
        OSS_OFF:
        begin
          // Wait for a stale done from a previous run to clear
          if (!s_q.internal_osc_select)
          begin
            s_d.st = OSS_EXTCLK;
          end
          else if (!s_q.done_s2)
          begin
            s_d.st = OSS_STARTUP;
          end
        end
        OSS_STARTUP:
        begin
          if (!s_q.internal_osc_select)
          begin
            s_d.st = OSS_OFF;
          end
          else if (s_q.done_s2)
          begin
            s_d.st = OSS_STABLE;
          end
        end
        OSS_STABLE:
        begin
          if (!s_q.internal_osc_select || !s_q.done_s2)
          begin
            s_d.st = OSS_OFF;
          end
        end
        default:
        begin
          if (s_q.internal_osc_select)
          begin
            s_d.st = OSS_OFF;
          end
        end
      endcase
    end

    if (wr_en)
    begin
      if (addr == OSS_CR_ADDR)
      begin
        s_d.ext_ref_enable      = wr_data[OSS_CR_EREN_BIT];
        s_d.ext_ref_stop_enable = wr_data[OSS_CR_STEN_BIT];
        // Load trim frozen while running, a change would upset start-up
        if (!running)
        begin
          s_d.cap = wr_data[OSS_CAP_W-1:0];
        end
      end
      else if (addr == OSS_CFG_ADDR)
      begin
        if (!running)
        begin
          s_d.internal_osc_select = wr_data[OSS_CFG_SEL_BIT];
        end
      end
    end

    // Wake from deepest stop wins over any write in the same cycle
    if (vlls_wake)
    begin
      s_d.ext_ref_enable      = OSS_EREN_RST;
      s_d.ext_ref_stop_enable = OSS_STEN_RST;
      s_d.cap                 = OSS_CAP_RST;
      s_d.internal_osc_select = OSS_SEL_RST;
    end

    if (rd_en)
    begin
      if (addr == OSS_CR_ADDR)
      begin
        s_d.rdata[OSS_CR_EREN_BIT]   = s_q.ext_ref_enable;
        s_d.rdata[OSS_CR_STEN_BIT]   = s_q.ext_ref_stop_enable;
        s_d.rdata[OSS_CAP_W-1:0]     = s_q.cap;
      end
      else if (addr == OSS_CFG_ADDR)
      begin
        s_d.rdata[OSS_CFG_SEL_BIT]   = s_q.internal_osc_select;
      end
      else if (addr == OSS_STAT_ADDR)
      begin
        s_d.rdata[OSS_ST_STATE_LSB+:2] = st_code;
        s_d.rdata[OSS_ST_DONE_BIT]     = s_q.done_s2;
        s_d.rdata[OSS_ST_EN_BIT]       = osc_en;
        s_d.rdata[OSS_ST_KEEP_BIT]     = s_q.keep;
      end
    end
  end

  // Settings survive stop and low-leakage stop; only reset or very-low-leakage wake clears them
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q     <= '0;
      s_q.st  <= OSS_OFF;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign lnk.osc_en     = osc_en;
  assign lnk.int_sel    = s_q.internal_osc_select;
  assign lnk.ref_active = ref_active;

  oss_raw_cnt #(
    .CYCLES (CYCLES)
  ) u_raw (
    .raw_osc_clk (raw_osc_clk),
    .rst         (rst),
    .lnk         (lnk.raw)
  );

  // No reset request or interrupt port exists on this block
  assign rd_data           = s_q.rdata;
  assign load_cap          = s_q.cap;
  assign amp_enable        = (s_q.st == OSS_STARTUP) | (s_q.st == OSS_STABLE);
  assign input_buf_enable  = running | ~s_q.internal_osc_select;
  assign drive_pad_release = ~amp_enable;
  assign osc_out_clk       = lnk.out_clk;
  assign ext_ref_clk       = lnk.ref_clk_out;

  chk_off_when_idle: assert property (
    @(posedge ref_clk) disable iff (rst)
    !osc_en |=> s_q.st == OSS_OFF)
    else $error("block not off without demand");

  chk_off_pads_cut: assert property (
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == OSS_OFF) |-> !amp_enable && drive_pad_release)
    else $error("amplifier active in off state");

  chk_startup_entry: assert property (
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == OSS_OFF && osc_en && s_q.internal_osc_select && !s_q.done_s2)
    |=> s_q.st == OSS_STARTUP)
    else $error("start-up not entered");

  chk_stable_cause: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(s_q.st == OSS_STABLE) |-> $past(s_q.done_s2) && $past(osc_en)
    && s_q.internal_osc_select)
    else $error("stable entered without done");

  chk_stable_hold: assert property (
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == OSS_STABLE && osc_en && s_q.done_s2 && s_q.internal_osc_select)
    |=> s_q.st == OSS_STABLE)
    else $error("stable state lost");

  chk_ext_entry: assert property (
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == OSS_OFF && osc_en && !s_q.internal_osc_select)
    |=> s_q.st == OSS_EXTCLK ##1 input_buf_enable)
    else $error("external mode not entered");

  chk_ext_pad_free: assert property (
    @(posedge ref_clk) disable iff (rst)
    (s_q.st == OSS_EXTCLK) |-> drive_pad_release && input_buf_enable)
    else $error("drive pad held in external mode");

  chk_stop_gate: assert property (
    @(posedge ref_clk) disable iff (rst)
    (in_stop && s_q.stop_q && !s_q.keep) |-> !osc_en ##1 s_q.st == OSS_OFF)
    else $error("oscillator running in stop");

  chk_stop_keep: assert property (
    @(posedge ref_clk) disable iff (rst)
    (stop_entry && s_q.ext_ref_enable && s_q.ext_ref_stop_enable)
    |-> ref_active ##1 (!in_stop || s_q.keep))
    else $error("reference lost on stop entry");

  chk_wake_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    vlls_wake |=> !s_q.ext_ref_enable && !s_q.ext_ref_stop_enable
    && s_q.cap == OSS_CAP_RST && !s_q.internal_osc_select)
    else $error("settings kept after deep wake");

  chk_ref_gate: assert property (
    @(posedge ref_clk) disable iff (rst)
    !s_q.ext_ref_enable |-> !ref_active)
    else $error("reference active while disabled");

  chk_cfg_frozen: assert property (
    @(posedge ref_clk) disable iff (rst)
    (running && !vlls_wake) |=> $stable(s_q.internal_osc_select))
    else $error("select changed while running");

  chk_rd_unmapped: assert property (
    @(posedge ref_clk) disable iff (rst)
    (rd_en && addr != OSS_CR_ADDR && addr != OSS_CFG_ADDR
    && addr != OSS_STAT_ADDR) |=> rd_data == OSS_RD_ZERO)
    else $error("unmapped read not zero");

  chk_rd_idle: assert property (
    @(posedge ref_clk) disable iff (rst)
    !rd_en |=> rd_data == OSS_RD_ZERO)
    else $error("read data outside answer cycle");

endmodule

// ==== oss_osc_drive_pad_model.sv ====
// Purpose: crystal or external clock source on the two pads
// Assumes: 30 ns period, phase unrelated to ref_clk
// Notes: crystal needs a few half periods to build up
`timescale 1ns/100ps
module oss_osc_drive_pad_model #(
  parameter int unsigned BUILD = 6
)
(
  output logic      raw_osc_clk,
  input  wire logic amp_enable,
  input  wire logic input_buf_enable,
  input  wire logic ext_src_on
);
  int unsigned build_cnt;
  logic        run;

  // Stands low outside oscillation so a stale edge never looks like a clock
  assign run = (amp_enable && build_cnt >= BUILD) || (ext_src_on && input_buf_enable);

  initial
  begin
    raw_osc_clk = 1'b0;
    build_cnt = 0;
    #7;
    forever
    begin
      #15;
      build_cnt = amp_enable ? build_cnt + 1 : 0;
      raw_osc_clk = run ? ~raw_osc_clk : 1'b0;
    end
  end
endmodule

// ==== oss_tb.sv ====
// Purpose: self-checking bench of the oscillator control block
// Assumes: start-up count shortened to 16
// Notes: raw edges are counted to judge the start-up gate
`timescale 1ns/100ps
module tb;
  import oss_pkg::*;
  localparam int unsigned CYC = 16;
  logic       ref_clk, rst, raw_osc_clk, wr_en, rd_en, ext_src_on;
  logic [7:0] addr, wr_data, rd_data;
  logic       consumer_req, stop_mode, low_leak_stop, very_low_leak_stop;
  logic [3:0] load_cap;
  logic       amp_enable, input_buf_enable, drive_pad_release, osc_out_clk, ext_ref_clk;
  int         bad_count, checked, raw_cnt, out_cnt, ref_cnt, first_out;
  logic [7:0] v;

  oss_top #(.CYCLES(CYC)) u_dut (.ref_clk(ref_clk), .rst(rst), .raw_osc_clk(raw_osc_clk),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .consumer_req(consumer_req), .stop_mode(stop_mode), .low_leak_stop(low_leak_stop),
    .very_low_leak_stop(very_low_leak_stop), .load_cap(load_cap),
    .amp_enable(amp_enable), .input_buf_enable(input_buf_enable),
    .drive_pad_release(drive_pad_release), .osc_out_clk(osc_out_clk),
    .ext_ref_clk(ext_ref_clk));
  oss_osc_drive_pad_model u_osc_drive_pad (.raw_osc_clk(raw_osc_clk), .amp_enable(amp_enable),
    .input_buf_enable(input_buf_enable), .ext_src_on(ext_src_on));

  always #10 ref_clk = ~ref_clk;
  always @(posedge raw_osc_clk) raw_cnt++;
  always @(posedge ext_ref_clk) ref_cnt++;
  always @(posedge osc_out_clk)
  begin
    out_cnt++;
    if (first_out < 0)
      first_out = raw_cnt;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    // Read data stand in this cycle only; take them mid-cycle where settled
    @(negedge ref_clk);
    d = rd_data;
    @(posedge ref_clk);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Polls state field under a bound, then compares it
  task automatic wait_state(input logic [1:0] s);
    int i;
    for (i = 0; i < 200; i++)
    begin
      rd(OSS_STAT_ADDR, v);
      if (v[1:0] === s)
        break;
    end
    chk({6'h00, v[1:0]}, {6'h00, s});
  endtask

  task automatic reg_test();
    rd(OSS_CR_ADDR, v);
    chk(v, 8'h00);
    chk({7'h00, drive_pad_release}, 8'h01);
    chk({7'h00, amp_enable}, 8'h00);
    rd(8'h0C, v);
    chk(v, 8'h00);
    wr(OSS_CR_ADDR, 8'h7F);
    rd(OSS_CR_ADDR, v);
    chk(v, 8'h2F);
    @(negedge ref_clk);
    chk(rd_data, 8'h00);
    chk({4'h0, load_cap}, 8'h0F);
    wr(OSS_CFG_ADDR, 8'hFF);
    rd(OSS_CFG_ADDR, v);
    chk(v, 8'h01);
    $display("reg_test done");
  endtask

  // Start-up: gate held for the full count, then clock passes
  task automatic startup_run();
    raw_cnt = 0;
    first_out = -1;
    consumer_req <= 1'b1;
    cyc(3);
    rd(OSS_STAT_ADDR, v);
    chk({6'h00, v[1:0]}, 8'h01);
    chk({7'h00, amp_enable}, 8'h01);
    chk({7'h00, drive_pad_release}, 8'h00);
    wait_state(OSS_STABLE);
    chk({7'h00, first_out >= int'(CYC)}, 8'h01);
  endtask

  task automatic osc_drive_pad_test();
    int n;
    wr(OSS_CR_ADDR, 8'h05);
    startup_run();
    rd(OSS_STAT_ADDR, v);
    chk(v, 8'h0E);
    n = out_cnt;
    ref_cnt = 0;
    cyc(20);
    chk({7'h00, out_cnt > n}, 8'h01);
    chk(ref_cnt[7:0], 8'h00);
    wr(OSS_CR_ADDR, 8'h85);
    cyc(20);
    chk({7'h00, ref_cnt > 0}, 8'h01);
    wr(OSS_CR_ADDR, 8'h05);
    consumer_req <= 1'b0;
    cyc(4);
    rd(OSS_STAT_ADDR, v);
    chk({6'h00, v[1:0]}, 8'h00);
    chk({7'h00, amp_enable}, 8'h00);
    chk({7'h00, input_buf_enable}, 8'h00);
    n = out_cnt;
    cyc(20);
    chk(out_cnt[7:0], n[7:0]);
    // Second start must count again from zero
    startup_run();
    consumer_req <= 1'b0;
    wait_state(OSS_OFF);
    $display("osc_drive_pad_test done");
  endtask

  task automatic ext_test();
    int n;
    wr(OSS_CFG_ADDR, 8'h00);
    ext_src_on <= 1'b1;
    consumer_req <= 1'b1;
    wait_state(OSS_EXTCLK);
    chk({7'h00, amp_enable}, 8'h00);
    chk({7'h00, drive_pad_release}, 8'h01);
    chk({7'h00, input_buf_enable}, 8'h01);
    n = out_cnt;
    cyc(20);
    chk({7'h00, out_cnt > n}, 8'h01);
    consumer_req <= 1'b0;
    $display("ext_test done");
  endtask

  task automatic stop_test();
    wr(OSS_CR_ADDR, 8'hA0);
    stop_mode <= 1'b1;
    cyc(4);
    ref_cnt = 0;
    rd(OSS_STAT_ADDR, v);
    chk(v & 8'h13, 8'h13);
    cyc(20);
    chk({7'h00, ref_cnt > 0}, 8'h01);
    stop_mode <= 1'b0;
    wr(OSS_CR_ADDR, 8'h80);
    stop_mode <= 1'b1;
    wait_state(OSS_OFF);
    stop_mode <= 1'b0;
    low_leak_stop <= 1'b1;
    cyc(4);
    // Select only takes while off, so set it inside the stop
    wr(OSS_CFG_ADDR, 8'h01);
    low_leak_stop <= 1'b0;
    rd(OSS_CR_ADDR, v);
    chk(v, 8'h80);
    rd(OSS_CFG_ADDR, v);
    chk(v, 8'h01);
    very_low_leak_stop <= 1'b1;
    cyc(4);
    very_low_leak_stop <= 1'b0;
    cyc(2);
    rd(OSS_CR_ADDR, v);
    chk(v, 8'h00);
    rd(OSS_CFG_ADDR, v);
    chk(v, 8'h00);
    $display("stop_test done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    {wr_en, rd_en, ext_src_on, consumer_req} = 4'h0;
    {stop_mode, low_leak_stop, very_low_leak_stop} = 3'h0;
    addr = 8'h00;
    wr_data = 8'h00;
    {bad_count, checked, raw_cnt, out_cnt, ref_cnt} = '0;
    first_out = -1;
    cyc(6);
    rst <= 1'b0;
    reg_test();
    osc_drive_pad_test();
    ext_test();
    stop_test();
    tally_and_finish();
  end

  // Whole run is a few hundred cycles; this is ample
  initial
  begin
    #400000;
    bad_count++;
    tally_and_finish();
  end
endmodule
